// *** acr_regulator.sv ***
// Behaviour
// - coil magnitudes are multiplied by (scale + 1) / 32.
// - the software current scale is the ceiling of the regulated scale.
// - reading below low threshold raises scale by 1, 2, 4 or 8.
// - scale drops by one after 32, 8, 2 or 1 high readings.
// - floor is a quarter of current scale when selected, otherwise half.
// - regulated scale is readable as a 5-bit status value.
// - regulated scale stays between the floor and the current scale.
// - averaging cuts evaluation rate and regulation speed to a quarter.
// - low threshold is low code times 32 against the 10-bit load.
// - high threshold is (low code + span + 1) times 32, inclusive.
// - each full-step reading, or each fourth when averaging, is one evaluation.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
module acr_regulator
    import acr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [31:0] rdata,
    input wire acr_load_t load_in,
    input wire acr_coil_t coil_in,
    output acr_coil_t coil_out,
    output logic [SCALE_W-1:0] adaptive_scale_actual
);
    logic [SCALE_W-1:0] cs_reg;
    acr_cfg_t cfg_reg;
    logic [SCALE_W-1:0] se_reg;
    logic [SCALE_W-1:0] se_next;
    logic [CNT_W-1:0] dn_cnt_reg;
    logic [CNT_W-1:0] dn_cnt_next;
    logic [LOAD_W-1:0] last_load_reg;
    logic [31:0] rdata_reg;
    acr_load_t eval;
    logic [LOAD_W:0] low_thr;
    logic [LOAD_W:0] high_thr;
    logic below;
    logic above;
    logic [SCALE_W-1:0] floor_val;
    logic [CNT_W-1:0] step;
    logic [CNT_W-1:0] need;
    logic [CNT_W-1:0] raised;

    acr_averager u_avg (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .avg_en(cfg_reg.load_average_en),
        .load_in(load_in),
        .eval_out(eval)
    );

    // software writes of scale and configuration
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cs_reg <= CS_RESET;
            cfg_reg <= '0;
        end else if (we) begin
            if (addr == ADDR_SCALE) begin
                cs_reg <= wdata[SCALE_W-1:0];
            end
            if (addr == ADDR_CFG) begin
                cfg_reg.low_threshold_code <= wdata[CFG_LOW_LSB +: 4];
                cfg_reg.high_threshold_span <= wdata[CFG_SPAN_LSB +: 4];
                cfg_reg.up_step_width <= wdata[CFG_UP_LSB +: 2];
                cfg_reg.down_sample_count <= wdata[CFG_DN_LSB +: 2];
                cfg_reg.floor_quarter_sel <= wdata[CFG_QSEL_BIT];
                cfg_reg.load_average_en <= wdata[CFG_AVG_BIT];
            end
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= '0;
            if (re) begin
                case (addr)
                    ADDR_SCALE: rdata_reg[SCALE_W-1:0] <= cs_reg;
                    ADDR_CFG: begin
                        rdata_reg[CFG_LOW_LSB +: 4] <= cfg_reg.low_threshold_code;
                        rdata_reg[CFG_SPAN_LSB +: 4] <= cfg_reg.high_threshold_span;
                        rdata_reg[CFG_UP_LSB +: 2] <= cfg_reg.up_step_width;
                        rdata_reg[CFG_DN_LSB +: 2] <= cfg_reg.down_sample_count;
                        rdata_reg[CFG_QSEL_BIT] <= cfg_reg.floor_quarter_sel;
                        rdata_reg[CFG_AVG_BIT] <= cfg_reg.load_average_en;
                    end
                    ADDR_STATUS: begin
                        rdata_reg[SCALE_W-1:0] <= se_reg;
                        rdata_reg[STAT_LOAD_LSB +: LOAD_W] <= last_load_reg;
                    end
                    default: rdata_reg <= '0;
                endcase
            end
        end
    end
    assign rdata = rdata_reg;

    // thresholds and comparison of the evaluated reading
    assign low_thr = (LOAD_W+1)'(cfg_reg.low_threshold_code) << THR_SHIFT;
    assign high_thr = ((LOAD_W+1)'(cfg_reg.low_threshold_code)
                      + (LOAD_W+1)'(cfg_reg.high_threshold_span)
                      + (LOAD_W+1)'(1)) << THR_SHIFT;
    assign below = {1'b0, eval.value} < low_thr;
    assign above = {1'b0, eval.value} >= high_thr;
    assign floor_val = cfg_reg.floor_quarter_sel ? (cs_reg >> 2) : (cs_reg >> 1);
    assign step = acr_up_step(cfg_reg.up_step_width);
    assign need = acr_dn_need(cfg_reg.down_sample_count);
    assign raised = CNT_W'(se_reg) + step;

    // regulation step then clamp into [floor, scale]
    always_comb begin
        dn_cnt_next = dn_cnt_reg;
        se_next = se_reg;
        if (eval.valid) begin
            if (below) begin
                se_next = (raised > CNT_W'(cs_reg)) ? cs_reg : raised[SCALE_W-1:0];
                dn_cnt_next = '0;
            end else if (above) begin
                if (dn_cnt_reg + CNT_W'(1) >= need) begin
                    dn_cnt_next = '0;
                    se_next = (se_reg != '0) ? se_reg - SCALE_W'(1) : se_reg;
                end else begin
                    dn_cnt_next = dn_cnt_reg + CNT_W'(1);
                end
            end else begin
                dn_cnt_next = '0;
            end
        end
        if (se_next > cs_reg) begin
            se_next = cs_reg;
        end
        if (se_next < floor_val) begin
            se_next = floor_val;
        end
    end

    // regulated scale and high-reading count
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            se_reg <= SE_RESET;
            dn_cnt_reg <= '0;
        end else begin
            se_reg <= se_next;
            dn_cnt_reg <= dn_cnt_next;
        end
    end

    // last evaluated load value for status
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            last_load_reg <= '0;
        end else if (eval.valid) begin
            last_load_reg <= eval.value;
        end
    end

    // scaled coil magnitudes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            coil_out <= '0;
        end else begin
            coil_out.a <= acr_scale_coil(coil_in.a, se_reg);
            coil_out.b <= acr_scale_coil(coil_in.b, se_reg);
        end
    end
    assign adaptive_scale_actual = se_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // coil scaling against the regulated scale of the cycle before
    a_coil_product: assert property (
        $past(nrst) |-> 32'(coil_out.a)
            == ((32'($past(coil_in.a)) * (32'($past(se_reg)) + 1)) >> FRAC_SHIFT))
        else $error("coil a not scaled by regulated factor");
    a_coil_b_product: assert property (
        $past(nrst) |-> 32'(coil_out.b)
            == ((32'($past(coil_in.b)) * (32'($past(se_reg)) + 1)) >> FRAC_SHIFT))
        else $error("coil b not scaled by regulated factor");

    // regulation and clamp checks
    a_scale_ceiling: assert property (
        !$past(we) |-> se_reg <= cs_reg)
        else $error("regulated scale above current scale");
    a_up_step: assert property (
        eval.valid && below && !we && raised <= CNT_W'(cs_reg)
        |=> CNT_W'(se_reg) == $past(raised))
        else $error("raise step size wrong");
    a_down_count: assert property (
        eval.valid && above && !we && dn_cnt_reg + CNT_W'(1) == need && se_reg > floor_val
        |=> se_reg == $past(se_reg) - SCALE_W'(1) && dn_cnt_reg == '0)
        else $error("decrement after count missing");
    a_floor_limit: assert property (
        !$past(we) |-> se_reg >= (cfg_reg.floor_quarter_sel ? cs_reg >> 2 : cs_reg >> 1))
        else $error("regulated scale under floor");
    a_status_word: assert property (
        re && addr == ADDR_STATUS |=> rdata[SCALE_W-1:0] == $past(se_reg) && rdata[15:5] == '0)
        else $error("status word does not show regulated scale");
    a_below_raises: assert property (
        eval.valid && 11'(eval.value) < 11'(cfg_reg.low_threshold_code) * 11'd32
        && se_reg < cs_reg && !we |=> se_reg > $past(se_reg))
        else $error("low reading did not raise scale");
    a_above_counts: assert property (
        eval.valid && above && !we && dn_cnt_reg + CNT_W'(1) < need
        |=> dn_cnt_reg == $past(dn_cnt_reg) + CNT_W'(1) && se_reg == $past(se_reg))
        else $error("high reading not counted");
    a_between_hold: assert property (
        eval.valid && !below && !above && !we |=> se_reg == $past(se_reg) && dn_cnt_reg == '0)
        else $error("mid reading changed scale or kept count");
    a_raise_saturate: assert property (
        eval.valid && below && !we && raised > CNT_W'(cs_reg) |=> se_reg == $past(cs_reg))
        else $error("raise did not stop at current scale");
    a_floor_hold: assert property (
        eval.valid && above && !we && dn_cnt_reg + CNT_W'(1) >= need && se_reg == floor_val
        |=> se_reg == $past(floor_val))
        else $error("decrement went under floor");

    // read port and status capture checks
    a_read_quiet: assert property (
        !$past(re) |-> rdata == '0)
        else $error("read data not zero outside read cycle");
    a_status_load: assert property (
        re && addr == ADDR_STATUS |=> rdata[STAT_LOAD_LSB +: LOAD_W] == $past(last_load_reg)
        && rdata[31:STAT_LOAD_LSB+LOAD_W] == '0)
        else $error("status load field wrong");
    a_load_capture: assert property (
        eval.valid |=> last_load_reg == $past(eval.value))
        else $error("evaluated load not captured");

    // main scenarios
    c_raise: cover property (eval.valid && below && se_reg < cs_reg);
    c_between: cover property (eval.valid && !below && !above);
    c_lower: cover property (eval.valid && above && dn_cnt_reg + CNT_W'(1) == need);
    c_at_floor: cover property (se_reg == floor_val && cs_reg != '0);
endmodule

// *** acr_pkg.sv ***
package acr_pkg;
    // load measurement and coil magnitude widths
    localparam int LOAD_W = 10;
    localparam int SCALE_W = 5;
    localparam int COIL_W = 8;
    localparam int CNT_W = 6;
    localparam int SUM_W = 12;
    localparam int AVG_SHIFT = 2;
    localparam int THR_SHIFT = 5;
    localparam int FRAC_SHIFT = 5;

    // register byte addresses
    localparam logic [7:0] ADDR_SCALE = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // field positions in the configuration and status words
    localparam int CFG_LOW_LSB = 0;
    localparam int CFG_SPAN_LSB = 4;
    localparam int CFG_UP_LSB = 8;
    localparam int CFG_DN_LSB = 10;
    localparam int CFG_QSEL_BIT = 12;
    localparam int CFG_AVG_BIT = 13;
    localparam int STAT_LOAD_LSB = 16;

    // reset values
    localparam logic [SCALE_W-1:0] CS_RESET = 5'h1f;
    localparam logic [SCALE_W-1:0] SE_RESET = 5'h1f;

    // averaging phases, gray order
    typedef enum logic [1:0] {
        ACR_PH0 = 2'b00,
        ACR_PH1 = 2'b01,
        ACR_PH2 = 2'b11,
        ACR_PH3 = 2'b10
    } acr_phase_t;

    typedef struct packed {
        logic [3:0] low_threshold_code;
        logic [3:0] high_threshold_span;
        logic [1:0] up_step_width;
        logic [1:0] down_sample_count;
        logic floor_quarter_sel;
        logic load_average_en;
    } acr_cfg_t;

    typedef struct packed {
        logic valid;
        logic [LOAD_W-1:0] value;
    } acr_load_t;

    typedef struct packed {
        logic [COIL_W-1:0] a;
        logic [COIL_W-1:0] b;
    } acr_coil_t;

    // raise step 1, 2, 4, 8
    function automatic logic [CNT_W-1:0] acr_up_step(input logic [1:0] code);
        acr_up_step = CNT_W'(1) << code;
    endfunction

    // readings per decrement 32, 8, 2, 1
    function automatic logic [CNT_W-1:0] acr_dn_need(input logic [1:0] code);
        case (code)
            2'h0: acr_dn_need = 6'h20;
            2'h1: acr_dn_need = 6'h08;
            2'h2: acr_dn_need = 6'h02;
            default: acr_dn_need = 6'h01;
        endcase
    endfunction

    // magnitude times (scale + 1) / 32
    function automatic logic [COIL_W-1:0] acr_scale_coil(input logic [COIL_W-1:0] v,
                                                         input logic [SCALE_W-1:0] s);
        logic [COIL_W+SCALE_W:0] p;
        p = (COIL_W+SCALE_W+1)'(v) * (COIL_W+SCALE_W+1)'({1'b0, s} + 6'h01);
        acr_scale_coil = p[COIL_W+FRAC_SHIFT-1:FRAC_SHIFT];
    endfunction
endpackage

// *** acr_averager.sv ***
module acr_averager
    import acr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic avg_en,
    input wire acr_load_t load_in,
    output acr_load_t eval_out
);
    acr_phase_t phase_reg;
    logic [SUM_W-1:0] sum_reg;
    logic [SUM_W-1:0] sum_all;

    assign sum_all = sum_reg + SUM_W'(load_in.value);

    // phase of the four-reading window
    always_ff @(posedge ref_clk) begin
        if (!nrst || !avg_en) begin
            phase_reg <= ACR_PH0;
        end else if (load_in.valid) begin
            case (phase_reg)
                ACR_PH0: phase_reg <= ACR_PH1;
                ACR_PH1: phase_reg <= ACR_PH2;
                ACR_PH2: phase_reg <= ACR_PH3;
                ACR_PH3: phase_reg <= ACR_PH0;
                default: phase_reg <= ACR_PH0;
            endcase
        end
    end

    // running sum, cleared after the fourth reading
    always_ff @(posedge ref_clk) begin
        if (!nrst || !avg_en) begin
            sum_reg <= '0;
        end else if (load_in.valid) begin
            sum_reg <= (phase_reg == ACR_PH3) ? '0 : sum_all;
        end
    end

    // one evaluation per reading, or per four when averaging
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            eval_out <= '0;
        end else if (!avg_en) begin
            eval_out.valid <= load_in.valid;
            eval_out.value <= load_in.value;
        end else begin
            eval_out.valid <= load_in.valid && phase_reg == ACR_PH3;
            eval_out.value <= sum_all[LOAD_W+AVG_SHIFT-1:AVG_SHIFT];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_avg_quarter_rate: assert property (
        eval_out.valid && $past(avg_en) |-> $past(load_in.valid) && $past(phase_reg) == ACR_PH3)
        else $error("averaged evaluation not on fourth reading");
    a_direct_pass: assert property (
        !avg_en && load_in.valid |=> eval_out.valid && eval_out.value == $past(load_in.value))
        else $error("reading not passed straight to evaluation");
    c_avg_eval: cover property (avg_en && load_in.valid && phase_reg == ACR_PH3);
endmodule

// *** acr_load_model.sv ***
module acr_load_model
    import acr_pkg::*;
(
    input wire logic ref_clk,
    output acr_load_t load_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial load_out = '0;
    // one reading per full step, after an idle gap of gap+1 cycles
    task automatic send(input logic [LOAD_W-1:0] v, input int gap);
        repeat (gap + 1) @(posedge ref_clk);
        load_out <= '{valid: 1'b1, value: v};
        @(posedge ref_clk);
        // released value shows the inverse, never a stale copy
        load_out <= '{valid: 1'b0, value: ~v};
    endtask
endmodule

// *** acr_regulator_tb_top.sv ***
module acr_regulator_tb_top
    import acr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, nrst, we, re;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [SCALE_W-1:0] se_out, cs_s;
    acr_load_t load_in;
    acr_coil_t coil_in, coil_out, ca;
    logic [13:0] m_cfg, cfg;
    int err_count, checks, cyc, m_cs, m_se, m_cnt, m_last, m_ph, m_acc;
    bit coil_en;

    // 100 mhz clock
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end

    acr_regulator dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .we(we),
        .re(re), .rdata(rdata), .load_in(load_in), .coil_in(coil_in), .coil_out(coil_out),
        .adaptive_scale_actual(se_out));
    acr_load_model lm (.ref_clk(ref_clk), .load_out(load_in));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // expected regulator state
    function automatic int floor_of();
        return m_cfg[12] ? m_cs >> 2 : m_cs >> 1;
    endfunction
    function automatic int need(input logic [1:0] c);
        return c == 0 ? 32 : c == 1 ? 8 : c == 2 ? 2 : 1;
    endfunction
    task automatic clampm();
        if (m_se > m_cs) m_se = m_cs;
        if (m_se < floor_of()) m_se = floor_of();
    endtask
    task automatic evalm(input int v);
        int lo, hi;
        lo = m_cfg[3:0] * 32;
        hi = (m_cfg[3:0] + m_cfg[7:4] + 1) * 32;
        m_last = v;
        if (v < lo) begin
            m_se += 1 << m_cfg[9:8];
            m_cnt = 0;
        end else if (v >= hi) begin
            m_cnt++;
            if (m_cnt >= need(m_cfg[11:10])) begin
                m_se--;
                m_cnt = 0;
            end
        end else
            m_cnt = 0;
        clampm();
    endtask

    // register bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        we <= 1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        we <= 0;
        if (a == ADDR_SCALE) m_cs = d[4:0];
        if (a == ADDR_CFG) begin
            m_cfg = d[13:0];
            if (!d[13]) begin
                m_ph = 0;
                m_acc = 0;
            end
        end
        clampm();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        re <= 1;
        addr <= a;
        @(posedge ref_clk);
        re <= 0;
        #1 check(rdata, exp);
        @(posedge ref_clk);
        #1 check(rdata, 32'h0);
    endtask

    // one load reading, then port and status compare
    task automatic reading(input int v);
        lm.send(v[9:0], $urandom_range(0, 2));
        if (m_cfg[13]) begin
            m_acc += v;
            m_ph++;
            if (m_ph == 4) begin
                evalm(m_acc >> 2);
                m_ph = 0;
                m_acc = 0;
            end
        end else
            evalm(v);
        repeat (3) @(posedge ref_clk);
        #1 check(32'(se_out), m_se);
        rd(ADDR_STATUS, (32'(m_last) << 16) | 32'(m_se));
    endtask

    // random coil magnitudes in, scaled magnitudes checked
    always @(posedge ref_clk) coil_in <= acr_coil_t'($urandom);
    always begin
        @(posedge ref_clk);
        ca = coil_in;
        cs_s = se_out;
        #1;
        if (coil_en) begin
            check(32'(coil_out.a), (32'(ca.a) * (32'(cs_s) + 1)) >> 5);
            check(32'(coil_out.b), (32'(ca.b) * (32'(cs_s) + 1)) >> 5);
        end
    end

    // hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        nrst = 0;
        we = 0;
        re = 0;
        addr = '0;
        wdata = '0;
        coil_in = '0;
        m_cs = 31;
        m_se = 31;
        m_cfg = '0;
        void'($urandom(28));
        repeat (10) @(posedge ref_clk);
        nrst <= 1;
        repeat (2) @(posedge ref_clk);
        coil_en = 1;
        rd(ADDR_SCALE, 32'h1f);
        rd(ADDR_CFG, 32'h0);
        rd(ADDR_STATUS, 32'h1f);
        rd(8'h0c, 32'h0);
        wr(ADDR_STATUS, 32'hffffffff);
        wr(8'h10, 32'hffffffff);
        rd(ADDR_SCALE, 32'h1f);
        rd(ADDR_CFG, 32'h0);
        // slowest decrement: 31 high readings hold, the 32nd drops
        wr(ADDR_CFG, 32'h0012);
        repeat (32) reading(500);
        // quarter floor, fastest decrement, step 8 saturating at scale
        wr(ADDR_SCALE, 32'h14);
        wr(ADDR_CFG, 32'h1f12);
        rd(ADDR_CFG, 32'h1f12);
        repeat (18) reading(500);
        repeat (2) reading(10);
        wr(ADDR_CFG, 32'h3f12);
        repeat (8) reading(1000);
        for (int k = 0; k < 16; k++) begin
            wr(ADDR_CFG, 32'h0);
            reading(0);
            wr(ADDR_SCALE, $urandom_range(0, 31));
            cfg = 14'($urandom_range(0, 16383));
            cfg[9:8] = k[1:0];
            cfg[11:10] = k[3:2];
            wr(ADDR_CFG, 32'(cfg));
            repeat (20) reading($urandom_range(0, 1023));
        end
        stop_test();
    end
endmodule
